// ---- verilog/sel_core.sv ----
// Exception priority, wait and halt sequencing, reset cause and status registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "sel_map.svh"
//
// What this block does
// - Software trap taken regardless of global mask
// - Trap stacks counter; hardware stacks counter minus one
// - Any reset beats every pending interrupt
// - Low-power instructions clear mask, stop CPU clock
// - Wait gates CPU clocks, peripheral clocks run
// - Enabled wait-live interrupt wakes, stacks next cycle
// - Reset ends wait; watchdog runs unless disabled
// - Halt keeps CPU and peripheral clocks off until recovery ends
// - Without oscillator option, halt kills clockgen outputs
// - Halt ends on halt-live interrupt or reset
// - Short recovery 32 ref cycles, else 4096
// - Stacking after halt waits for full recovery
// - Reset exit from halt always uses long recovery
// - Counter cleared in halt, then times recovery
// - Cause register records source of last reset
// - Reading cause register clears all bits
// - Power-on sets its bit, clears others
// - Global mask blocks all but software trap
// - Sources 1-9 own status flag, 10-11 none; priority 0 to 11
// - Status A flags 1-5 at bits 2-6
// - Unused flag positions always read zero
// - Take only unmasked enabled; highest priority first
module sel_core
    import sel_pkg::*;
#(
    parameter int NSRC = `SEL_NSRC,
    parameter int REF_DIV = `SEL_REF_DIV,
    parameter int LONG_REC = `SEL_LONG_REC,
    parameter int SHORT_REC = `SEL_SHORT_REC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input sel_axil_req_t axi_req,
    output sel_axil_rsp_t axi_rsp,
    input wire logic instr_done,
    input wire logic swi_exec,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic ccr_imask,
    input wire logic [NSRC:1] src_req,
    input wire logic [NSRC:1] src_en,
    input wire logic [NSRC:1] src_wait_live,
    input wire logic [NSRC:1] src_stop_live,
    input sel_rst_src_t rst_src,
    output sel_clk_ctl_t clk_ctl,
    output logic imask_clear,
    output logic irq_take,
    output logic [3:0] irq_pri,
    output logic stack_pc_minus1,
    output logic chip_reset,
    output logic watchdog_run
);
    localparam int DIV_W = $clog2(REF_DIV + 1);

    sel_state_t state_reg;
    sel_state_t state_next;
    logic [2:0] cfg_reg;
    logic [7:0] cause_reg;
    logic rec_long_reg;
    logic [DIV_W-1:0] div_reg;
    logic ref_tick;
    logic ref_run;
    logic rec_done;
    logic [`SEL_REC_W-1:0] rec_limit;
    logic wr_stb;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_stb;
    logic [15:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic any_rst;
    logic [NSRC:1] armed;
    logic [4:0] pick_run;
    logic [4:0] wake_wait;
    logic [4:0] wake_stop;
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic cause_rd;

    // Lowest number is highest priority; bit 4 flags a hit
    function automatic logic [4:0] sel_pick(input logic [NSRC:1] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NSRC; i >= 1; i--) begin
            if (v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Address decode shared by read and write
    function automatic logic sel_hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    sel_axil_slave u_bus (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Interrupt qualification and wake sources
    assign any_rst = |rst_src;
    assign armed = src_req & src_en;
    assign pick_run = sel_pick(armed);
    assign wake_wait = sel_pick(armed & src_wait_live);
    assign wake_stop = sel_pick(armed & src_stop_live);

    // Status views; unused positions tied low
    assign stat_a = {1'b0, src_req[5:1], 2'b00};
    assign stat_b = {src_req[9:`SEL_FIRST_B_PRI], 4'h0};

    // Read data mux; status registers are read only
    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h00000000;
        if (sel_hit(rd_addr, `SEL_ADDR_CAUSE)) begin
            rd_data = {24'h000000, cause_reg};
        end else if (sel_hit(rd_addr, `SEL_ADDR_STAT_A)) begin
            rd_data = {24'h000000, stat_a};
        end else if (sel_hit(rd_addr, `SEL_ADDR_STAT_B)) begin
            rd_data = {24'h000000, stat_b};
        end else if (sel_hit(rd_addr, `SEL_ADDR_CFG)) begin
            rd_data = {29'h00000000, cfg_reg};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Writes to mapped addresses answer OKAY, even where ignored
    assign wr_ok = sel_hit(wr_addr, `SEL_ADDR_CAUSE) || sel_hit(wr_addr, `SEL_ADDR_STAT_A)
                || sel_hit(wr_addr, `SEL_ADDR_STAT_B) || sel_hit(wr_addr, `SEL_ADDR_CFG);
    assign cause_rd = rd_stb && sel_hit(rd_addr, `SEL_ADDR_CAUSE);

    // Configuration register, only writable location
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= `SEL_CFG_RESET;
        end else if (wr_stb && wr_strb[0] && sel_hit(wr_addr, `SEL_ADDR_CFG)) begin
            cfg_reg <= wr_data[2:0];
        end
    end

    // Reset cause bits; new cause wins over read clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cause_reg <= `SEL_CAUSE_RESET;
        end else if (rst_src.por) begin
            cause_reg <= `SEL_CAUSE_RESET;
        end else begin
            cause_reg <= (cause_rd ? 8'h00 : cause_reg)
                | (8'(rst_src.watchdog) << `SEL_CAUSE_WDOG)
                | (8'(rst_src.bad_opcode) << `SEL_CAUSE_BAD_OP)
                | (8'(rst_src.bad_address) << `SEL_CAUSE_BAD_ADDR)
                | (8'(rst_src.forced_monitor) << `SEL_CAUSE_MONITOR)
                | (8'(rst_src.low_voltage) << `SEL_CAUSE_LOW_V);
        end
    end

    // Reference clock runs unless halted without oscillator option
    assign ref_run = !(state_reg == SEL_STOP && !cfg_reg[`SEL_CFG_OSC]);
    assign ref_tick = ref_run && (div_reg == DIV_W'(REF_DIV - 1));

    // Divider giving one tick per reference clock cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= '0;
        end else if (!ref_run || ref_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    // Recovery length: reset exit or long setting gives full count
    assign rec_limit = rec_long_reg ? `SEL_REC_W'(LONG_REC) : `SEL_REC_W'(SHORT_REC);

    sel_recovery_ctr #(
        .W(`SEL_REC_W)
    ) u_rec (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .hold(state_reg != SEL_RECOVER || any_rst),
        .tick(ref_tick),
        .limit(rec_limit),
        .done(rec_done)
    );

    // Mode sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEL_RUN: begin
                if (!any_rst && instr_done && !swi_exec) begin
                    if (wait_exec) begin
                        state_next = SEL_WAIT;
                    end else if (stop_exec) begin
                        state_next = SEL_STOP;
                    end
                end
            end
            SEL_WAIT: begin
                if (any_rst) begin
                    state_next = SEL_RUN;
                end else if (wake_wait[4]) begin
                    state_next = SEL_TAKE;
                end
            end
            SEL_STOP: begin
                if (any_rst || wake_stop[4]) begin
                    state_next = SEL_RECOVER;
                end
            end
            SEL_RECOVER: begin
                if (rec_done && !any_rst) begin
                    state_next = rec_long_reg && !wake_stop[4] ? SEL_RUN : SEL_TAKE;
                end
            end
            SEL_TAKE: begin
                state_next = SEL_RUN;
            end
            default: begin
                state_next = SEL_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= SEL_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Recovery length choice latched on halt exit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rec_long_reg <= 1'b1;
        end else if (state_reg == SEL_STOP && state_next == SEL_RECOVER) begin
            rec_long_reg <= any_rst || !cfg_reg[`SEL_CFG_SHORT];
        end else if (state_reg == SEL_RECOVER && any_rst) begin
            rec_long_reg <= 1'b1;
        end
    end

    // Interrupt take with stacking type and priority
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_take <= 1'b0;
            irq_pri <= `SEL_SWI_PRI;
            stack_pc_minus1 <= 1'b0;
        end else begin
            irq_take <= 1'b0;
            if (any_rst) begin
                irq_take <= 1'b0;
            end else if (state_reg == SEL_RUN && instr_done && swi_exec) begin
                irq_take <= 1'b1;
                irq_pri <= `SEL_SWI_PRI;
                stack_pc_minus1 <= 1'b0;
            end else if (state_reg == SEL_RUN && instr_done && !ccr_imask
                         && !wait_exec && !stop_exec && pick_run[4]) begin
                irq_take <= 1'b1;
                irq_pri <= pick_run[3:0];
                stack_pc_minus1 <= 1'b1;
            end else if (state_reg == SEL_TAKE && pick_run[4]) begin
                irq_take <= 1'b1;
                irq_pri <= pick_run[3:0];
                stack_pc_minus1 <= 1'b1;
            end
        end
    end

    // Mask clear pulse on low-power entry
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            imask_clear <= 1'b0;
        end else begin
            imask_clear <= state_reg == SEL_RUN
                && (state_next == SEL_WAIT || state_next == SEL_STOP);
        end
    end

    // Reset request forwarded, never arbitrated against interrupts
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= any_rst;
        end
    end

    // Clock gating from the coming mode
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clk_ctl <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                         clockgen_bus_out_en: 1'b1, clockgen_ref_clk_en: 1'b1};
        end else begin
            case (state_next)
                SEL_WAIT: begin
                    clk_ctl <= '{cpu_clk_en: 1'b0, periph_clk_en: 1'b1,
                                 clockgen_bus_out_en: 1'b1, clockgen_ref_clk_en: 1'b1};
                end
                SEL_STOP: begin
                    clk_ctl <= '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                                 clockgen_bus_out_en: cfg_reg[`SEL_CFG_OSC],
                                 clockgen_ref_clk_en: cfg_reg[`SEL_CFG_OSC]};
                end
                SEL_RECOVER: begin
                    clk_ctl <= '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0,
                                 clockgen_bus_out_en: 1'b1, clockgen_ref_clk_en: 1'b1};
                end
                default: begin
                    clk_ctl <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                                 clockgen_bus_out_en: 1'b1, clockgen_ref_clk_en: 1'b1};
                end
            endcase
        end
    end

    // Watchdog keeps running in wait unless disabled
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_run <= 1'b1;
        end else begin
            watchdog_run <= !cfg_reg[`SEL_CFG_WDOG_DIS]
                && state_next != SEL_STOP && state_next != SEL_RECOVER;
        end
    end
endmodule

// ---- verilog/sel_map.svh ----
// Register map, field positions, reset values and timing counts
`ifndef SEL_MAP_SVH
`define SEL_MAP_SVH
`define SEL_ADDR_CAUSE 16'hFE00
`define SEL_ADDR_STAT_A 16'hFE04
`define SEL_ADDR_STAT_B 16'hFE08
`define SEL_ADDR_CFG 16'hFE0C
`define SEL_CAUSE_POR 7
`define SEL_CAUSE_WDOG 6
`define SEL_CAUSE_BAD_OP 5
`define SEL_CAUSE_BAD_ADDR 4
`define SEL_CAUSE_MONITOR 3
`define SEL_CAUSE_LOW_V 1
`define SEL_CAUSE_RESET 8'h80
`define SEL_CFG_RESET 3'h0
`define SEL_CFG_SHORT 0
`define SEL_CFG_OSC 1
`define SEL_CFG_WDOG_DIS 2
`define SEL_STAT_A_LO 2
`define SEL_STAT_B_LO 4
`define SEL_FIRST_B_PRI 6
`define SEL_LONG_REC 4096
`define SEL_SHORT_REC 32
`define SEL_REF_DIV 8
`define SEL_REC_W 13
`define SEL_NSRC 11
`define SEL_SWI_PRI 4'h0
`define SEL_RESP_OKAY 2'h0
`define SEL_RESP_SLVERR 2'h2
`endif

// ---- verilog/sel_pkg.sv ----
// Types shared by the exception and low-power control block
package sel_pkg;
    typedef struct packed {
        logic awvalid;
        logic [15:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [15:0] araddr;
        logic rready;
    } sel_axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sel_axil_rsp_t;
    typedef struct packed {
        logic por;
        logic watchdog;
        logic bad_opcode;
        logic bad_address;
        logic forced_monitor;
        logic low_voltage;
    } sel_rst_src_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic clockgen_bus_out_en;
        logic clockgen_ref_clk_en;
    } sel_clk_ctl_t;
    typedef enum logic [2:0] {
        SEL_RUN = 3'b000,
        SEL_WAIT = 3'b001,
        SEL_STOP = 3'b010,
        SEL_RECOVER = 3'b011,
        SEL_TAKE = 3'b100
    } sel_state_t;
endpackage

// ---- verilog/sel_recovery_ctr.sv ----
// Halt recovery counter clocked by reference clock ticks
module sel_recovery_ctr #(
    parameter int W = 13
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hold,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] count_reg;

    // Cleared while held, then counts ticks up to the limit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (hold) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (tick) begin
            count_reg <= count_reg + W'(1);
            done <= (count_reg == limit - W'(1));
        end else begin
            done <= 1'b0;
        end
    end
endmodule

// ---- verilog/sel_axil_slave.sv ----
// AXI4-Lite slave front end with single outstanding read and write
module sel_axil_slave
    import sel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input sel_axil_req_t axi_req,
    output sel_axil_rsp_t axi_rsp,
    output logic wr_stb,
    output logic [15:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_stb,
    output logic [15:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
`include "sel_map.svh"
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Write fires once address and data are both held
    assign wr_stb = !awready_reg && !wready_reg && !bvalid_reg;
    assign rd_stb = axi_req.arvalid && arready_reg;
    assign rd_addr = axi_req.araddr;

    // Write address and data capture, in either order
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            wr_addr <= 16'h0000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (wr_stb) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end else begin
            if (axi_req.awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                wr_addr <= axi_req.awaddr;
            end
            if (axi_req.wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wr_data <= axi_req.wdata;
                wr_strb <= axi_req.wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `SEL_RESP_OKAY;
        end else if (wr_stb) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? `SEL_RESP_OKAY : `SEL_RESP_SLVERR;
        end else if (axi_req.bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `SEL_RESP_OKAY;
        end else if (rd_stb) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_ok ? rd_data : 32'h00000000;
            rresp_reg <= rd_ok ? `SEL_RESP_OKAY : `SEL_RESP_SLVERR;
        end else if (rvalid_reg && axi_req.rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign axi_rsp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                       bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                       rdata: rdata_reg, rresp: rresp_reg};
endmodule

// ---- bench/sel_cpu_model.sv ----
// CPU core stand-in that completes instructions and tracks the global mask
module sel_cpu_model (
    input wire logic clk_sys,
    input wire logic irq_take,
    input wire logic imask_clear,
    output logic instr_done,
    output logic [2:0] kind,
    output logic ccr_imask
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        instr_done = 1'b0;
        kind = 3'h0;
        ccr_imask = 1'b1;
    end
    // Mask set on interrupt entry, cleared on low-power entry
    always @(posedge clk_sys) begin
        if (imask_clear)
            ccr_imask <= 1'b0;
        else if (irq_take)
            ccr_imask <= 1'b1;
    end
    // One instruction completes; answer sampled an edge later
    task automatic run(input logic [2:0] k, output logic tk);
        instr_done <= 1'b1;
        kind <= k;
        @(posedge clk_sys);
        instr_done <= 1'b0;
        kind <= 3'h0;
        @(posedge clk_sys);
        tk = irq_take;
    endtask
    task automatic set_mask(input logic v);
        @(posedge clk_sys);
        ccr_imask <= v;
    endtask
endmodule

// ---- bench/sel_core_checker.sv ----
// Port-level checks of exception and low-power sequencing
module sel_core_checker
    import sel_pkg::*;
#(
    parameter int REF_DIV = 8,
    parameter int SHORT_REC = 32
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic instr_done,
    input wire logic swi_exec,
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic ccr_imask,
    input sel_rst_src_t rst_src,
    input sel_clk_ctl_t clk_ctl,
    input wire logic imask_clear,
    input wire logic irq_take,
    input wire logic [3:0] irq_pri,
    input wire logic stack_pc_minus1,
    input wire logic chip_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic any_rst;
    logic go;
    int off_cnt;
    // Qualified instruction completion
    assign any_rst = |rst_src;
    assign go = instr_done && !swi_exec && !any_rst;
    // Cycles with peripheral clocks gated
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            off_cnt <= 0;
        else if (clk_ctl.periph_clk_en)
            off_cnt <= 0;
        else
            off_cnt <= off_cnt + 1;
    end
    a_reset_wins: assert property (any_rst |=> chip_reset && !irq_take)
        else $error("reset did not beat interrupt");
    a_swi_taken: assert property (instr_done && swi_exec && !any_rst
        |=> irq_take && irq_pri == 4'h0 && !stack_pc_minus1)
        else $error("software trap not taken");
    a_hw_pc: assert property (irq_take && irq_pri != 4'h0 |-> stack_pc_minus1)
        else $error("hardware take without pc minus one");
    a_mask_holds: assert property (go && ccr_imask && !wait_exec && !stop_exec
        |=> !irq_take)
        else $error("masked interrupt taken");
    a_lp_entry: assert property (go && (wait_exec || stop_exec)
        |=> imask_clear && !clk_ctl.cpu_clk_en)
        else $error("low-power entry wrong");
    a_wait_clks: assert property (go && wait_exec |=> clk_ctl.periph_clk_en [*3])
        else $error("peripheral clocks stopped in wait");
    a_halt_clks: assert property (go && stop_exec
        |=> !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en)
        else $error("clocks running in halt");
    a_recover_len: assert property ($rose(clk_ctl.periph_clk_en)
        |-> off_cnt >= (SHORT_REC - 1) * REF_DIV)
        else $error("recovery too short");
    a_take_clk: assert property (irq_take |-> clk_ctl.cpu_clk_en)
        else $error("stacking with clocks off");
    c_swi: cover property (instr_done && swi_exec);
    c_halt: cover property ($fell(clk_ctl.periph_clk_en));
    c_hw_take: cover property (irq_take && irq_pri != 4'h0);
endmodule
bind sel_core sel_core_checker #(.REF_DIV(REF_DIV), .SHORT_REC(SHORT_REC)) chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .instr_done(instr_done), .swi_exec(swi_exec),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .ccr_imask(ccr_imask),
    .rst_src(rst_src), .clk_ctl(clk_ctl), .imask_clear(imask_clear),
    .irq_take(irq_take), .irq_pri(irq_pri), .stack_pc_minus1(stack_pc_minus1),
    .chip_reset(chip_reset)
);

// ---- bench/sel_core_bench.sv ----
// Self-checking bench for the exception and low-power control block
`include "sel_map.svh"
module sys_exception_lowpower_ctrl_bench
    import sel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys;
    logic rst_b;
    sel_axil_req_t req;
    sel_axil_rsp_t rsp;
    logic [11:1] s_req;
    logic [11:1] s_en;
    logic [11:1] s_wl;
    logic [11:1] s_sl;
    sel_rst_src_t rs;
    sel_clk_ctl_t ck;
    logic instr_done;
    logic [2:0] kind;
    logic ccr;
    logic imclr;
    logic take;
    logic [3:0] pri;
    logic pcm1;
    logic chip_rst;
    logic wdog;
    logic [31:0] rd;
    logic [1:0] rr;
    logic tk;
    int n;
    int error_cnt = 0;
    int check_count = 0;
    int cbit[6] = '{1, 3, 4, 5, 6, 7};
    sel_core #(.REF_DIV(2), .LONG_REC(16), .SHORT_REC(4)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
        .instr_done(instr_done), .swi_exec(kind[2]), .wait_exec(kind[1]),
        .stop_exec(kind[0]), .ccr_imask(ccr), .src_req(s_req), .src_en(s_en),
        .src_wait_live(s_wl), .src_stop_live(s_sl), .rst_src(rs), .clk_ctl(ck),
        .imask_clear(imclr), .irq_take(take), .irq_pri(pri),
        .stack_pc_minus1(pcm1), .chip_reset(chip_rst), .watchdog_run(wdog)
    );
    sel_cpu_model cpu (
        .clk_sys(clk_sys), .irq_take(take), .imask_clear(imclr),
        .instr_done(instr_done), .kind(kind), .ccr_imask(ccr)
    );
    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // AXI4-Lite write, address and data together
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (rsp.awready && req.awvalid)
                req.awvalid <= 1'b0;
            if (rsp.wready && req.wvalid)
                req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rr = rsp.bresp;
    endtask
    // AXI4-Lite read
    task automatic axi_rd(input logic [15:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (rsp.arready)
                req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd = rsp.rdata;
        rr = rsp.rresp;
    endtask
    task automatic pulse(input sel_rst_src_t v);
        rs <= v;
        @(posedge clk_sys);
        rs <= '0;
        @(posedge clk_sys);
    endtask
    // Cycles until a take (s=0) or the CPU clock returns (s=1)
    task automatic wait_for(input int s);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(s ? ck.cpu_clk_en : take) && n < 300);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial begin
        #40000;
        error_cnt++;
        wrap_up();
    end
    // Test sequence
    initial begin
        rst_b = 1'b0;
        req = '0;
        s_req = '0;
        s_en = '1;
        s_wl = 11'h002;
        s_sl = 11'h001;
        rs = '0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        axi_rd(`SEL_ADDR_CAUSE);
        chk(rd, 32'h80);
        axi_rd(`SEL_ADDR_CAUSE);
        chk(rd, 32'h0);
        axi_rd(16'hFE10);
        chk(rr, `SEL_RESP_SLVERR);
        axi_wr(16'hFE10, 32'hFF);
        chk(rr, `SEL_RESP_SLVERR);
        foreach (cbit[i]) begin
            pulse(6'h1 << i);
            chk(chip_rst, 1'b1);
            axi_rd(`SEL_ADDR_CAUSE);
            chk(rd, 32'h1 << cbit[i]);
        end
        pulse(6'h10);
        pulse(6'h20);
        axi_rd(`SEL_ADDR_CAUSE);
        chk(rd, 32'h80);
        $display("test reset_cause done");
        s_req <= 11'h775;
        for (int w = 0; w < 2; w++) begin
            axi_rd(`SEL_ADDR_STAT_A);
            chk(rd, 32'h54);
            axi_rd(`SEL_ADDR_STAT_B);
            chk(rd, 32'hB0);
            axi_wr(`SEL_ADDR_STAT_A, 32'hFF);
            axi_wr(`SEL_ADDR_STAT_B, 32'hFF);
        end
        $display("test status done");
        s_req <= 11'h018;
        cpu.set_mask(1'b0);
        cpu.run(3'h0, tk);
        chk({tk, pri, pcm1}, {1'b1, 4'h4, 1'b1});
        cpu.run(3'h0, tk);
        chk(tk, 1'b0);
        cpu.run(3'h4, tk);
        chk({tk, pri, pcm1}, {1'b1, 4'h0, 1'b0});
        cpu.set_mask(1'b0);
        s_en <= '0;
        cpu.run(3'h0, tk);
        chk(tk, 1'b0);
        s_en <= '1;
        rs <= 6'h10;
        cpu.run(3'h0, tk);
        rs <= '0;
        chk(tk, 1'b0);
        s_req <= '0;
        $display("test interrupts done");
        for (int d = 0; d < 2; d++) begin
            axi_wr(`SEL_ADDR_CFG, d << 2);
            cpu.run(3'h2, tk);
            chk({ck.cpu_clk_en, ck.periph_clk_en, wdog}, {2'b01, d == 0});
            s_req <= 11'h001;
            cyc(10);
            chk(ck.cpu_clk_en, 1'b0);
            s_req <= 11'h002;
            wait_for(0);
            chk({n[27:0], pri}, {28'd3, 4'h2});
            s_req <= '0;
        end
        cpu.run(3'h2, tk);
        pulse(6'h01);
        cyc(3);
        chk(ck.cpu_clk_en, 1'b1);
        $display("test wait done");
        for (int h = 0; h < 2; h++) begin
            axi_wr(`SEL_ADDR_CFG, h ? 32'h1 : 32'h2);
            cpu.run(3'h1, tk);
            chk(ck, {2'b00, h == 0, h == 0});
            s_req <= 11'h002;
            cyc(40);
            chk(ck.periph_clk_en, 1'b0);
            s_req <= 11'h001;
            wait_for(0);
            chk(n >= (h ? 8 : 32) && n <= (h ? 16 : 40), 1'b1);
            s_req <= '0;
        end
        cpu.run(3'h1, tk);
        cyc(4);
        pulse(6'h01);
        wait_for(1);
        chk(n >= 30 && n <= 40, 1'b1);
        $display("test halt done");
        wrap_up();
    end
endmodule
